// >>> design/oact_cfg.svh
`ifndef OACT_CFG_SVH
`define OACT_CFG_SVH

`define OACT_ADDR_W          4
`define OACT_OFS_AMP0_CTRL   4'h0
`define OACT_OFS_AMP1_CTRL   4'h4
`define OACT_OFS_AMP0_TRIM   4'h8
`define OACT_OFS_AMP1_TRIM   4'hc

`define OACT_CTRL_EN_BIT     6
`define OACT_CTRL_STAT_BIT   5
`define OACT_CTRL_BW_LSB     0
`define OACT_TRIM_CAL_BIT    7
`define OACT_TRIM_REF_BIT    6
`define OACT_TRIM_VAL_LSB    0

`define OACT_CTRL_RST        8'h00
`define OACT_TRIM_RST        8'h20
`define OACT_CTRL_WMASK      8'h43

`define OACT_RESP_OKAY       2'b00
`define OACT_RESP_SLVERR     2'b10

`endif

// >>> design/oact_pkg.sv
`default_nettype none
package oact_pkg;

  typedef enum logic [1:0] {
    OACT_BW_5K   = 2'h0,
    OACT_BW_40K  = 2'h1,
    OACT_BW_600K = 2'h2,
    OACT_BW_2M   = 2'h3
  } oact_bw_e;

  typedef struct packed {
    logic     enable;
    oact_bw_e bandwidth_sel;
    logic     cal_mode;
    logic     cal_ref_sel;
    logic [5:0] offset_trim_value;
  } oact_amp_cfg_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } oact_wreq_s;

  typedef enum logic [2:0] {
    OACT_ST_IDLE = 3'b001,
    OACT_ST_RESP = 3'b010,
    OACT_ST_HOLD = 3'b100
  } oact_wst_e;

endpackage
`default_nettype wire

// >>> design/oact_pin_sync.sv
`default_nettype none
module oact_pin_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change only once two late stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule // oact_pin_sync
`default_nettype wire

// >>> design/oact_regs.sv
`include "oact_cfg.svh"
`default_nettype none

// Notes on behaviour
// R1 - With calibration mode set, an amplifier's read-only status bit returns its comparator output level.
// R2 - With calibration mode clear, the status bit reads as a constant low.
// R3 - The second amplifier's status bit is gated by its own calibration mode in the same way.
// R4 - Bit 6 of each control register is the read/write amplifier enable, 1 enabling it.
// R5 - Bits 1 to 0 of each control register select bandwidth 5kHz, 40kHz, 600kHz or 2MHz.
// R6 - Bit 7 of each trim register puts the amplifier in offset calibration mode when 1.
// R7 - Bit 6 of each trim register selects the inverting input (0) or non-inverting input (1) as reference.
// R8 - Bits 5 to 0 of each trim register hold a read/write six-bit offset trim value.
// R9 - Writes to read-only or unimplemented bits do nothing, and unimplemented bits read as zero.
module oact_regs (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [3:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [3:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  amp0_comp_out,
  input  wire logic                  amp1_comp_out,
  output var  oact_pkg::oact_amp_cfg_s amp0_cfg,
  output var  oact_pkg::oact_amp_cfg_s amp1_cfg
);
  import oact_pkg::*;

  logic [7:0] ctrl_q [2];
  logic [7:0] trim_q [2];
  logic [1:0] comp_lvl;
  logic       aw_held_q;
  logic       w_held_q;
  logic [3:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_strb0_q;
  logic       aw_take;
  logic       w_take;
  logic       wr_fire;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_strb0;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic [1:0] comp_raw;

  assign comp_raw = {amp1_comp_out, amp0_comp_out};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      oact_pin_sync u_sync (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (comp_raw[gi]),
        .level_out (comp_lvl[gi])
      );
    end
  endgenerate

  function automatic logic addr_hit(input logic [3:0] a);
    addr_hit = (a == `OACT_OFS_AMP0_CTRL) || (a == `OACT_OFS_AMP1_CTRL) ||
               (a == `OACT_OFS_AMP0_TRIM) || (a == `OACT_OFS_AMP1_TRIM);
  endfunction

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_addr       = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = w_held_q ? w_data_q : s_axi_wdata[7:0];
  assign wr_strb0      = w_held_q ? w_strb0_q : s_axi_wstrb[0];
  assign wr_fire       = (aw_held_q || aw_take) && (w_held_q || w_take);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb0_q <= 1'b0;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end else if (w_take) begin
      w_held_q  <= 1'b1;
      w_data_q  <= s_axi_wdata[7:0];
      w_strb0_q <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OACT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_hit(wr_addr) ? `OACT_RESP_OKAY : `OACT_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers keep only enable and bandwidth; status is never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q[0] <= `OACT_CTRL_RST;
      ctrl_q[1] <= `OACT_CTRL_RST;
    end else if (wr_fire && wr_strb0) begin
      if (wr_addr == `OACT_OFS_AMP0_CTRL) begin
        ctrl_q[0] <= wr_data & `OACT_CTRL_WMASK; // R4 R5 R9
      end
      if (wr_addr == `OACT_OFS_AMP1_CTRL) begin
        ctrl_q[1] <= wr_data & `OACT_CTRL_WMASK; // R4 R5 R9
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q[0] <= `OACT_TRIM_RST;
      trim_q[1] <= `OACT_TRIM_RST;
    end else if (wr_fire && wr_strb0) begin
      if (wr_addr == `OACT_OFS_AMP0_TRIM) begin
        trim_q[0] <= wr_data; // R6 R7 R8
      end
      if (wr_addr == `OACT_OFS_AMP1_TRIM) begin
        trim_q[1] <= wr_data; // R6 R7 R8
      end
    end
  end

  // Status bit gated by each amplifier's own calibration mode
  function automatic logic [7:0] ctrl_view(input int unsigned idx);
    logic [7:0] v;
    v = ctrl_q[idx] & `OACT_CTRL_WMASK; // R9
    v[`OACT_CTRL_STAT_BIT] = trim_q[idx][`OACT_TRIM_CAL_BIT] & comp_lvl[idx]; // R1 R2 R3
    ctrl_view = v;
  endfunction

  always_comb begin
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `OACT_OFS_AMP0_CTRL: rd_byte = ctrl_view(0);
      `OACT_OFS_AMP1_CTRL: rd_byte = ctrl_view(1);
      `OACT_OFS_AMP0_TRIM: rd_byte = trim_q[0];
      `OACT_OFS_AMP1_TRIM: rd_byte = trim_q[1];
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OACT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte}; // R9
      s_axi_rresp  <= rd_hit ? `OACT_RESP_OKAY : `OACT_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Analog-facing configuration, straight from the registers
  always_comb begin
    amp0_cfg.enable            = ctrl_q[0][`OACT_CTRL_EN_BIT]; // R4
    amp0_cfg.bandwidth_sel     = oact_bw_e'(ctrl_q[0][`OACT_CTRL_BW_LSB +: 2]); // R5
    amp0_cfg.cal_mode          = trim_q[0][`OACT_TRIM_CAL_BIT]; // R6
    amp0_cfg.cal_ref_sel       = trim_q[0][`OACT_TRIM_REF_BIT]; // R7
    amp0_cfg.offset_trim_value = trim_q[0][`OACT_TRIM_VAL_LSB +: 6]; // R8
    amp1_cfg.enable            = ctrl_q[1][`OACT_CTRL_EN_BIT]; // R4
    amp1_cfg.bandwidth_sel     = oact_bw_e'(ctrl_q[1][`OACT_CTRL_BW_LSB +: 2]); // R5
    amp1_cfg.cal_mode          = trim_q[1][`OACT_TRIM_CAL_BIT]; // R6
    amp1_cfg.cal_ref_sel       = trim_q[1][`OACT_TRIM_REF_BIT]; // R7
    amp1_cfg.offset_trim_value = trim_q[1][`OACT_TRIM_VAL_LSB +: 6]; // R8
  end
endmodule // oact_regs
`default_nettype wire

// >>> dv/oact_regs_props.sv
`include "oact_cfg.svh"
`default_nettype none
module oact_regs_props (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [3:0]              s_axi_araddr,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_bvalid,
  input wire oact_pkg::oact_amp_cfg_s amp0_cfg,
  input wire oact_pkg::oact_amp_cfg_s amp1_cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  import oact_pkg::*;
  logic [3:0] rd_addr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_addr_q <= 4'h0;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read data just presented for an accepted address
  sequence rd_done(g);
    $rose(s_axi_rvalid) && g;
  endsequence
  a_stat0_gated: assert property (rd_done(rd_addr_q == `OACT_OFS_AMP0_CTRL && !$past(amp0_cfg.cal_mode))
    |-> !s_axi_rdata[5]) else $error("amp0 status not low");
  a_stat1_gated: assert property (rd_done(rd_addr_q == `OACT_OFS_AMP1_CTRL && !$past(amp1_cfg.cal_mode))
    |-> !s_axi_rdata[5]) else $error("amp1 status not low");
  a_ctrl0_fields: assert property (rd_done(rd_addr_q == `OACT_OFS_AMP0_CTRL) |-> s_axi_rdata[31:6] ==
    {25'h0, $past(amp0_cfg.enable)} && s_axi_rdata[4:0] == {3'h0, $past(amp0_cfg.bandwidth_sel)})
    else $error("amp0 control readback wrong");
  a_ctrl1_bw: assert property (rd_done(rd_addr_q == `OACT_OFS_AMP1_CTRL)
    |-> s_axi_rdata[1:0] == $past(amp1_cfg.bandwidth_sel)) else $error("amp1 bandwidth readback wrong");
  a_trim0_fields: assert property (rd_done(rd_addr_q == `OACT_OFS_AMP0_TRIM) |-> s_axi_rdata ==
    {24'h0, $past(amp0_cfg.cal_mode), $past(amp0_cfg.cal_ref_sel), $past(amp0_cfg.offset_trim_value)})
    else $error("amp0 trim readback wrong");
  a_trim1_value: assert property (rd_done(rd_addr_q == `OACT_OFS_AMP1_TRIM)
    |-> s_axi_rdata[5:0] == $past(amp1_cfg.offset_trim_value)) else $error("amp1 trim readback wrong");
  a_unmapped_read: assert property (rd_done(rd_addr_q[1:0] != 2'h0)
    |-> s_axi_rresp == `OACT_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_cfg_by_write: assert property ($changed(amp0_cfg) || $changed(amp1_cfg) |-> $rose(s_axi_bvalid))
    else $error("config changed without write");
endmodule // oact_regs_props
bind oact_regs oact_regs_props oact_regs_props_i (.clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .amp0_cfg, .amp1_cfg);
`default_nettype wire

// >>> dv/tb_opamp_ctrl_trim_regs.sv
`include "oact_cfg.svh"
`default_nettype none
module tb_opamp_ctrl_trim_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import oact_pkg::*;
  localparam logic [1:0] OK = `OACT_RESP_OKAY;
  localparam logic [1:0] ERR = `OACT_RESP_SLVERR;
  logic          clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic          s_axi_arvalid = 0, s_axi_rready = 0, amp0_comp_out = 0, amp1_comp_out = 0;
  logic [3:0]    s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0]   s_axi_wdata = 0, s_axi_rdata;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  oact_amp_cfg_s amp0_cfg, amp1_cfg;
  int            failures = 0, checks = 0;
  logic [3:0]    wstrb_use = 4'hf;
  always #20 clk = ~clk;
  oact_regs oact_regs_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .amp0_comp_out, .amp1_comp_out,
    .amp0_cfg, .amp1_cfg);
  task automatic summarize;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stall(input logic seen);
    if (seen !== 1'b1) begin
      failures++;
      $display("Error at %0t: no bus response", $time);
      summarize();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'hffffff, d};
    s_axi_wstrb <= wstrb_use;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    stall(s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'b0;
    stall(s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge clk);
  endtask
  task automatic s_reset;
    for (int i = 0; i < 4; i++)
      rd(4'(i * 4), i < 2 ? 32'h0 : 32'h20, OK);
  endtask
  task automatic s_ctrl;
    for (int i = 0; i < 8; i++) begin
      logic [3:0] a;
      logic [1:0] bw;
      oact_amp_cfg_s c;
      a = i[0] ? `OACT_OFS_AMP1_CTRL : `OACT_OFS_AMP0_CTRL;
      bw = 2'(3 - (i >> 1));
      wr(a, {1'b1, i[1], 4'hf, bw}, OK);
      rd(a, {24'h0, 1'b0, i[1], 4'h0, bw}, OK);
      c = i[0] ? amp1_cfg : amp0_cfg;
      chk(32'({c.enable, c.bandwidth_sel}), 32'({i[1], bw}));
    end
  endtask
  task automatic s_trim;
    for (int i = 0; i < 4; i++) begin
      logic [3:0] a;
      logic [7:0] d;
      oact_amp_cfg_s c;
      a = i[0] ? `OACT_OFS_AMP1_TRIM : `OACT_OFS_AMP0_TRIM;
      d = i[1] ? 8'h6a : 8'h95;
      wr(a, d, OK);
      rd(a, {24'h0, d}, OK);
      c = i[0] ? amp1_cfg : amp0_cfg;
      chk(32'({c.cal_mode, c.cal_ref_sel, c.offset_trim_value}), 32'(d));
    end
  endtask
  task automatic s_status;
    wr(`OACT_OFS_AMP0_TRIM, 8'h80, OK);
    amp0_comp_out <= 1'b1;
    amp1_comp_out <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`OACT_OFS_AMP0_CTRL, 32'h60, OK);
    rd(`OACT_OFS_AMP1_CTRL, 32'h40, OK);
    wr(`OACT_OFS_AMP1_TRIM, 8'hc0, OK);
    amp0_comp_out <= 1'b0;
    repeat (8) @(posedge clk);
    rd(`OACT_OFS_AMP1_CTRL, 32'h60, OK);
    rd(`OACT_OFS_AMP0_CTRL, 32'h40, OK);
    wr(`OACT_OFS_AMP0_TRIM, 8'h00, OK);
    amp0_comp_out <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`OACT_OFS_AMP0_CTRL, 32'h40, OK);
  endtask
  task automatic s_strobe;
    wstrb_use = 4'he;
    wr(`OACT_OFS_AMP1_TRIM, 8'h11, OK);
    wstrb_use = 4'hf;
    rd(`OACT_OFS_AMP1_TRIM, 32'hc0, OK);
    chk(32'(amp1_cfg.offset_trim_value), 32'h0);
  endtask
  task automatic s_unmapped;
    wr(4'h1, 8'hff, ERR);
    rd(4'h1, 32'h0, ERR);
    rd(`OACT_OFS_AMP0_CTRL, 32'h40, OK);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    s_reset();
    s_ctrl();
    s_trim();
    s_status();
    s_strobe();
    s_unmapped();
    summarize();
  end
endmodule // tb_opamp_ctrl_trim_regs
`default_nettype wire
